// ### src/gp_pin_and_syserr_irq_capture.v
// Interrupt capture for eight general-purpose pins and sixteen
// internal system error sources, with a Wishbone register slave.
// Assumes error inputs are synchronous to mclk; pins pass a two-stage synchroniser.
//
// What this block does
// R1 - Latch each pin detection into pending bit
// R2 - Writing one clears that bit only
// R3 - Pending reads zero after reset, one pending
// R4 - Each pin interrupt maskable by mask bit
// R5 - Mask one enables, zero masks, resets zero
// R6 - Polarity zero falling/low, one rising/high
// R7 - Edge/level plus polarity choose four detections
// R8 - Source 15 failsafe, 14 fallback
// R9 - Sources 13..11 discard timer expiries
// R10 - Sources 10..8 target protocol errors
// R11 - Sources 7..2 master and buffer errors
// R12 - Source 1 scratchpad, 0 queue overflow
// R13 - System sources latched in two pending bytes
// R14 - System sources masked by two mask bytes
// R15 - Pending ignores mask; AND feeds request
// R16 - Edges from consecutive samples; edge mode at reset
`include "gp_irq_defines.vh"

module gp_pin_and_syserr_irq_capture #(
   parameter PINS = 8                   // General-purpose pin count
) (
   // Clock and reset
   input  wire                mclk,
   input  wire                rst,
   // Wishbone slave
   input  wire                cyc_i,
   input  wire                stb_i,
   input  wire                we_i,
   input  wire [31:0]         adr_i,
   input  wire [3:0]          sel_i,
   input  wire [31:0]         dat_i,
   output reg  [31:0]         dat_o,
   output reg                 ack_o,
   // General-purpose pins
   input  wire [PINS-1:0]     general_purpose_pins,
   // Internal system error sources
   input  wire                syserr_clock_failsafe,
   input  wire                syserr_clock_fallback,
   input  wire                syserr_bridge_discard_timeout,
   input  wire                syserr_vcmem_discard_timeout,
   input  wire                syserr_datamem_discard_timeout,
   input  wire                syserr_bridge_protocol_fault,
   input  wire                syserr_vcmem_protocol_fault,
   input  wire                syserr_datamem_protocol_fault,
   input  wire                syserr_master_fatal,
   input  wire                syserr_extbuf_lock,
   input  wire                syserr_extbuf_stall,
   input  wire                syserr_extbuf_stall_warn,
   input  wire                syserr_extbuf_overwrite_warn,
   input  wire                syserr_extbuf_initial_warn,
   input  wire                syserr_scratchpad_overflow,
   input  wire                syserr_event_fifo_overflow,
   // Combined interrupt request
   output reg                 irq
);

   // Software visible registers
   reg  [PINS-1:0] pin_pend;            // Pin event pending
   reg  [PINS-1:0] pin_mask;            // Pin event unmask
   reg  [PINS-1:0] pin_trig;            // One selects level mode
   reg  [PINS-1:0] pin_pol;             // Trigger sense
   reg  [15:0]     sys_pend;            // System error pending
   reg  [15:0]     sys_mask;            // System error unmask

   // Pin sampling pipeline
   reg  [PINS-1:0] pin_sync1;           // First synchroniser stage
   reg  [PINS-1:0] pin_sync2;           // Second synchroniser stage
   reg  [PINS-1:0] pin_prev;            // Previous sample of stage two
   wire [PINS-1:0] pin_hit;             // Detection this cycle

   // Bus decode
   wire [10:0]     reg_idx;             // Word index of access
   wire            bus_req;             // Request present
   wire            wr_fire;             // Write takes effect now
   wire [7:0]      wr_byte;             // Low byte lane data
   reg  [31:0]     next_dat;            // Read data to register

   // Next register values
   reg  [PINS-1:0] next_pin_pend;
   reg  [15:0]     next_sys_pend;
   wire [15:0]     sys_src;             // System sources as a vector

   // Map each system source to its fixed bit
   assign sys_src[`SYS_CLK_FAILSAFE]   = syserr_clock_failsafe;  // [R8]
   assign sys_src[`SYS_CLK_FALLBACK]   = syserr_clock_fallback;  // [R8]
   assign sys_src[`SYS_BRIDGE_DISCARD] =
      syserr_bridge_discard_timeout;                           // [R9]
   assign sys_src[`SYS_VCMEM_DISCARD]  =
      syserr_vcmem_discard_timeout;                            // [R9]
   assign sys_src[`SYS_DMEM_DISCARD]   =
      syserr_datamem_discard_timeout;                          // [R9]
   assign sys_src[`SYS_BRIDGE_PROTO]   =
      syserr_bridge_protocol_fault;                            // [R10]
   assign sys_src[`SYS_VCMEM_PROTO]    =
      syserr_vcmem_protocol_fault;                             // [R10]
   assign sys_src[`SYS_DMEM_PROTO]     =
      syserr_datamem_protocol_fault;                           // [R10]
   assign sys_src[`SYS_MASTER_FATAL]   = syserr_master_fatal;    // [R11]
   assign sys_src[`SYS_EXTBUF_LOCK]    = syserr_extbuf_lock;     // [R11]
   assign sys_src[`SYS_EXTBUF_STALL]   = syserr_extbuf_stall;    // [R11]
   assign sys_src[`SYS_STALL_WARN]     =
      syserr_extbuf_stall_warn;                                // [R11]
   assign sys_src[`SYS_OVERWRITE_WARN] =
      syserr_extbuf_overwrite_warn;                            // [R11]
   assign sys_src[`SYS_INITIAL_WARN]   =
      syserr_extbuf_initial_warn;                              // [R11]
   assign sys_src[`SYS_SCRATCH_OVF]    =
      syserr_scratchpad_overflow;                              // [R12]
   assign sys_src[`SYS_FIFO_OVF]       =
      syserr_event_fifo_overflow;                              // [R12]

   // Bus decode; index from the word address bits
   assign reg_idx = adr_i[12:2];
   assign bus_req = cyc_i & stb_i;
   // Write lands on the edge where the master sees ack
   assign wr_fire = bus_req & we_i & ack_o & sel_i[0];
   assign wr_byte = dat_i[7:0];

   // Per-pin detector: four modes from level flag and polarity
   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : det
         wire s;                        // Current sample
         wire p;                        // Previous sample
         assign s = pin_sync2[g];
         assign p = pin_prev[g];
         // Level mode fires every cycle the level holds
         assign pin_hit[g] = pin_trig[g] ?
            (pin_pol[g] ? s : ~s) :                 // [R7] [R16]
            (pin_pol[g] ? (s & ~p) : (~s & p));     // [R6] [R16]
      end
   endgenerate

   // Pin sampling: two stages, then previous-sample register
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_sync1 <= {PINS{1'b0}};
         pin_sync2 <= {PINS{1'b0}};
         pin_prev  <= {PINS{1'b0}};
      end else begin
         pin_sync1 <= general_purpose_pins;
         pin_sync2 <= pin_sync1;
         pin_prev  <= pin_sync2;        // [R16]
      end
   end

   // Pending update: a detection wins over a same-cycle clear
   always @* begin
      next_pin_pend = pin_pend;
      next_sys_pend = sys_pend;
      // Write one clears only that bit
      if (wr_fire && reg_idx == `PIN_PEND_IDX) begin
         next_pin_pend = pin_pend & ~wr_byte[PINS-1:0]; // [R2]
      end
      if (wr_fire && reg_idx == `SYS_PEND_L_IDX) begin
         next_sys_pend[7:0] = sys_pend[7:0] & ~wr_byte;  // [R13]
      end
      if (wr_fire && reg_idx == `SYS_PEND_H_IDX) begin
         next_sys_pend[15:8] = sys_pend[15:8] & ~wr_byte; // [R13]
      end
      // Capture regardless of mask
      next_pin_pend = next_pin_pend | pin_hit;   // [R1] [R15]
      next_sys_pend = next_sys_pend | sys_src;   // [R13] [R15]
   end

   // Pending registers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_pend <= `PIN_PEND_RST;     // [R3]
         sys_pend <= `SYS_PEND_RST;
      end else begin
         pin_pend <= next_pin_pend;     // [R1] [R3]
         sys_pend <= next_sys_pend;     // [R13]
      end
   end

   // Control registers written by software
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_mask <= `PIN_MASK_RST;     // [R5]
         pin_trig <= `PIN_TRIG_RST;
         pin_pol  <= `PIN_POL_RST;      // [R6]
         sys_mask <= `SYS_MASK_RST;     // [R14]
      end else if (wr_fire) begin
         case (reg_idx)
            `PIN_MASK_IDX: begin
               pin_mask <= wr_byte[PINS-1:0];  // [R4] [R5]
            end
            `PIN_TRIG_IDX: begin
               pin_trig <= wr_byte[PINS-1:0];  // [R7]
            end
            `PIN_POL_IDX: begin
               pin_pol <= wr_byte[PINS-1:0];   // [R6]
            end
            `SYS_MASK_L_IDX: begin
               sys_mask[7:0] <= wr_byte;       // [R14]
            end
            `SYS_MASK_H_IDX: begin
               sys_mask[15:8] <= wr_byte;      // [R14]
            end
            default: begin
               // Other offsets hold no writable control
            end
         endcase
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always @* begin
      next_dat = 32'h0000_0000;
      case (reg_idx)
         `PIN_PEND_IDX: begin
            next_dat[PINS-1:0] = pin_pend;     // [R3]
         end
         `PIN_MASK_IDX: begin
            next_dat[PINS-1:0] = pin_mask;
         end
         `PIN_TRIG_IDX: begin
            next_dat[PINS-1:0] = pin_trig;
         end
         `PIN_POL_IDX: begin
            next_dat[PINS-1:0] = pin_pol;
         end
         `SYS_PEND_L_IDX: begin
            next_dat[7:0] = sys_pend[7:0];
         end
         `SYS_PEND_H_IDX: begin
            next_dat[7:0] = sys_pend[15:8];
         end
         `SYS_MASK_L_IDX: begin
            next_dat[7:0] = sys_mask[7:0];
         end
         `SYS_MASK_H_IDX: begin
            next_dat[7:0] = sys_mask[15:8];
         end
         default: begin
            next_dat = 32'h0000_0000;
         end
      endcase
   end

   // Bus answer: ack one cycle after request, dropped after one
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req & ~ack_o;
         // Read data is captured with the ack
         if (bus_req && !ack_o && !we_i) begin
            dat_o <= next_dat;
         end
      end
   end

   // Combined request: only unmasked pending bits
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(pin_pend & pin_mask)) |
                (|(sys_pend & sys_mask));  // [R4] [R14] [R15]
      end
   end

endmodule // gp_pin_and_syserr_irq_capture

// ### include/gp_irq_defines.vh
// Register map, field layout and reset values of the pin and system
// error interrupt capture block.
// Assumes a 32-bit classic Wishbone slave with one byte per word.
`ifndef GP_IRQ_DEFINES_VH
`define GP_IRQ_DEFINES_VH

// Register indices; byte address is four times the index
`define PIN_PEND_IDX   11'h604
`define PIN_MASK_IDX   11'h605
`define PIN_TRIG_IDX   11'h606
`define PIN_POL_IDX    11'h607
`define SYS_PEND_L_IDX 11'h608
`define SYS_PEND_H_IDX 11'h609
`define SYS_MASK_L_IDX 11'h60a
`define SYS_MASK_H_IDX 11'h60b

// Reset values
`define PIN_PEND_RST   8'h00
`define PIN_MASK_RST   8'h00
`define PIN_TRIG_RST   8'h00
`define PIN_POL_RST    8'h00
`define SYS_PEND_RST   16'h0000
`define SYS_MASK_RST   16'h0000

// System error source bit positions
`define SYS_CLK_FAILSAFE   15
`define SYS_CLK_FALLBACK   14
`define SYS_BRIDGE_DISCARD 13
`define SYS_VCMEM_DISCARD  12
`define SYS_DMEM_DISCARD   11
`define SYS_BRIDGE_PROTO   10
`define SYS_VCMEM_PROTO    9
`define SYS_DMEM_PROTO     8
`define SYS_MASTER_FATAL   7
`define SYS_EXTBUF_LOCK    6
`define SYS_EXTBUF_STALL   5
`define SYS_STALL_WARN     4
`define SYS_OVERWRITE_WARN 3
`define SYS_INITIAL_WARN   2
`define SYS_SCRATCH_OVF    1
`define SYS_FIFO_OVF       0

`endif

// ### verification/gp_irq_assertions.sv
// Checker for the pin and system error interrupt capture block.
// Sees only top-level ports; bound from the bench top file.
module gp_irq_chk (
   // Clock, reset, bus and request
   input wire        mclk, rst, cyc_i, stb_i, we_i, ack_o, irq,
   input wire [31:0] adr_i, dat_o,
   // Watched error sources
   input wire        syserr_clock_failsafe, syserr_event_fifo_overflow
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire [10:0] idx = adr_i[12:2];                 // Register index
   wire        rd  = cyc_i && stb_i && !we_i && !ack_o; // Read taken
   // Reads of the two system pending bytes
   sequence hi_rd; rd && idx == 11'h609; endsequence
   sequence lo_rd; rd && idx == 11'h608; endsequence
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held past one cycle");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   chk_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 0)
      else $error("read data upper bits set");
   chk_unmapped_zero: assert property (rd && (idx < 11'h604
      || idx > 11'h60b) |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_data_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
      else $error("read data moved outside a read");
   chk_syserr_clock_failsafe_capt: assert property (syserr_clock_failsafe ##1 hi_rd
      |=> dat_o[7])
      else $error("failsafe source not pending");
   chk_syserr_event_fifo_overflow_capt: assert property (syserr_event_fifo_overflow ##1 lo_rd
      |=> dat_o[0])
      else $error("queue overflow source not pending");
endmodule // gp_irq_chk

// ### verification/gp_pin_and_syserr_irq_capture_tb_top.sv
// Self-checking bench: register access, pin detection, system errors.
// Assumes the one-cycle registered Wishbone answer of the block.
module gp_pin_and_syserr_irq_capture_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic [31:0] adr = 0, dat = 0, dat_o;
   logic [7:0]  pins = 8'hff, q;       // Pins idle high
   logic [15:0] se = 0;                // System error sources
   logic [10:0] ad;
   logic        ack, irq;
   int          n_mismatch = 0, n_tests = 0, cyc_n = 0;
   always #2.5 mclk = ~mclk;           // 200 MHz
   gp_pin_and_syserr_irq_capture #(.PINS(8)) dut_u (
      .mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .general_purpose_pins(pins), .irq(irq),
      .syserr_clock_failsafe(se[15]), .syserr_clock_fallback(se[14]),
      .syserr_bridge_discard_timeout(se[13]),
      .syserr_vcmem_discard_timeout(se[12]),
      .syserr_datamem_discard_timeout(se[11]),
      .syserr_bridge_protocol_fault(se[10]),
      .syserr_vcmem_protocol_fault(se[9]),
      .syserr_datamem_protocol_fault(se[8]),
      .syserr_master_fatal(se[7]), .syserr_extbuf_lock(se[6]),
      .syserr_extbuf_stall(se[5]), .syserr_extbuf_stall_warn(se[4]),
      .syserr_extbuf_overwrite_warn(se[3]),
      .syserr_extbuf_initial_warn(se[2]),
      .syserr_scratchpad_overflow(se[1]), .syserr_event_fifo_overflow(se[0]));
   // One classic Wishbone cycle, then one idle cycle
   task automatic bus(input logic w, input logic [10:0] i,
                      input logic [7:0] d);
      cyc <= 1; stb <= 1; we <= w; adr <= {19'h0, i, 2'b00};
      dat <= {24'h0, d};
      do @(posedge mclk); while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 0; stb <= 0;
      @(posedge mclk);
   endtask
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Compare irq one edge later: irq follows a pending or mask register change by one edge
   task automatic irq_is(input logic [7:0] e);
      @(posedge mclk);
      chk({7'h0, irq}, e);
   endtask
   // Read a register and compare
   task automatic rc(input logic [10:0] i, input logic [7:0] e);
      bus(0, i, 8'h00);
      chk(q, e);
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n > 4000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   initial begin
      wt(12);
      rst <= 0;
      wt(1);
      for (int i = 'h604; i <= 'h60b; i++) rc(i, 8'h00);
      bus(1, 11'h700, 8'hff);
      rc(11'h700, 8'h00);
      bus(1, 11'h605, 8'ha5);
      rc(11'h605, 8'ha5);
      bus(1, 11'h605, 8'h00);
      $display("test access done");
      pins <= 8'hfe;  // Falling edge on pin 0
      wt(4);
      rc(11'h604, 8'h01);
      irq_is(8'h00);
      bus(1, 11'h605, 8'h01);
      irq_is(8'h01);
      bus(1, 11'h604, 8'hfe);
      rc(11'h604, 8'h01);
      bus(1, 11'h604, 8'h01);
      rc(11'h604, 8'h00);
      irq_is(8'h00);
      bus(1, 11'h607, 8'h02);
      pins <= 8'hfc;  // Falling pin 1 ignored in rising mode
      wt(4);
      rc(11'h604, 8'h00);
      pins <= 8'hfe;
      wt(4);
      rc(11'h604, 8'h02);
      bus(1, 11'h604, 8'h02);
      bus(1, 11'h606, 8'h04);
      pins <= 8'hfa;  // Pin 2 low level
      wt(4);
      bus(1, 11'h604, 8'h04);
      rc(11'h604, 8'h04);
      pins <= 8'hfe;
      bus(1, 11'h607, 8'h06);
      bus(1, 11'h604, 8'h04);
      rc(11'h604, 8'h04);
      bus(1, 11'h606, 8'h00);
      bus(1, 11'h604, 8'h04);
      rc(11'h604, 8'h00);
      $display("test pins done");
      for (int b = 0; b < 16; b++) begin
         ad = (b < 8) ? 11'h608 : 11'h609;
         @(posedge mclk) se <= 16'h1 << b;
         @(posedge mclk) se <= 16'h0;
         rc(ad, 8'h01 << (b % 8));
         irq_is(8'h00);
         bus(1, ad, 8'h01 << (b % 8));
         rc(ad, 8'h00);
      end
      bus(1, 11'h60b, 8'h80);
      @(posedge mclk) se <= 16'h8000;
      @(posedge mclk) se <= 16'h0;
      wt(2);
      irq_is(8'h01);
      bus(1, 11'h609, 8'h80);
      irq_is(8'h00);
      bus(1, 11'h60a, 8'h01);
      @(posedge mclk) se <= 16'h0001;
      @(posedge mclk) se <= 16'h0;
      wt(1);
      irq_is(8'h01);
      bus(1, 11'h608, 8'h01);
      irq_is(8'h00);
      $display("test system done");
      tally_and_finish;
   end
endmodule // gp_pin_and_syserr_irq_capture_tb_top
bind gp_pin_and_syserr_irq_capture gp_irq_chk chk_u (.mclk, .rst, .cyc_i,
   .stb_i, .we_i, .ack_o, .irq, .adr_i, .dat_o, .syserr_clock_failsafe,
   .syserr_event_fifo_overflow);
